// [core/btk_cfg.svh]
// constants of the backup timekeeper: register map, field positions, reset values
// assumes the includer uses 32-bit avalon data and byte addressing
`ifndef BTK_CFG_SVH
`define BTK_CFG_SVH

// register byte addresses
`define BTK_ADDR_CTRL       6'h00
`define BTK_ADDR_SECONDS    6'h04
`define BTK_ADDR_DAYS       6'h08
`define BTK_ADDR_ALARM_SEC  6'h0c
`define BTK_ADDR_ALARM_DAY  6'h10
`define BTK_ADDR_TRIM       6'h14
`define BTK_ADDR_IRQ_STAT   6'h18
`define BTK_ADDR_IRQ_MASK   6'h1c
`define BTK_ADDR_STATUS     6'h20

// field widths
`define BTK_SEC_W           17
`define BTK_DAY_W           15
`define BTK_TRIM_W          5
`define BTK_DIV_W           16
`define BTK_CTRL_W          7
`define BTK_IRQ_W           3
`define BTK_STATUS_W        4

// irq flag positions
`define BTK_IRQ_TICK        0
`define BTK_IRQ_ALARM       1
`define BTK_IRQ_LOST        2

// counter limits
`define BTK_SEC_LAST        17'h1517f
`define BTK_DIV_LAST        16'h7fff

// trim policy codes
`define BTK_POL_OFF         2'h0
`define BTK_POL_MAIN_ONLY   2'h1
`define BTK_POL_ALWAYS      2'h3

// reset values
`define BTK_CTRL_RST        7'h00
`define BTK_IRQ_STAT_RST    3'h4
`define BTK_IRQ_MASK_RST    3'h7
`define BTK_SEC_RST         17'h00000
`define BTK_DAY_RST         15'h0000
`define BTK_TRIM_RST        5'h00
`define BTK_DIV_RST         16'h0000

`endif

// [core/btk_pkg.sv]
// types of the backup timekeeper
// assumes btk_cfg.svh is on the include path
`include "btk_cfg.svh"

package btk_pkg;

  // software control word
  typedef struct packed {
    logic [1:0] trim_policy;
    logic [2:0] charge_level;
    logic       charge_on;
    logic       timekeeper_off;
  } btk_ctrl_t;

  // supply and mode pins, all asynchronous to sys_clk
  typedef struct packed {
    logic app_on;
    logic main_below_uv;
    logic cell_above_main;
    logic main_below_1v8;
    logic osc_32k;
  } btk_pins_t;

  // charger and power-path outputs
  typedef struct packed {
    logic       on_backup_power;
    logic       cell_connected;
    logic       charge_current_high;
    logic       charge_current_low;
  } btk_power_t;

endpackage

// [core/btk_divider.sv]
// one-second divider of the backup timekeeper with signed trim
// assumes osc_rise is a one-cycle pulse per synchronised oscillator edge
`include "btk_cfg.svh"

module btk_divider (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_sync_n,
  // control
  input  wire logic                     run,
  input  wire logic                     trim_en,
  input  wire logic [`BTK_TRIM_W-1:0]   trim_word,
  input  wire logic                     osc_rise,
  // result
  output logic                          tick
);
  logic [`BTK_DIV_W-1:0] div_reg;
  logic [`BTK_DIV_W-1:0] last_next;
  logic                  tick_reg;

  // period is 32768 plus the signed trim; trim touches only this count
  always_comb begin
    if (trim_en) begin
      last_next = `BTK_DIV_LAST + {{(`BTK_DIV_W-`BTK_TRIM_W){trim_word[`BTK_TRIM_W-1]}},
                                   trim_word};
    end else begin
      last_next = `BTK_DIV_LAST;
    end
  end

  // stopping holds the phase so the draw is saved
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_reg  <= `BTK_DIV_RST;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      if (run && osc_rise) begin
        if (div_reg >= last_next) begin
          div_reg  <= `BTK_DIV_RST;
          tick_reg <= 1'b1;
        end else begin
          div_reg <= div_reg + 16'h0001;
        end
      end
    end
  end

  assign tick = tick_reg;
endmodule

// [core/btk_timekeeper.sv]
// backup timekeeper: seconds and day counters, alarm, flags, trim policy and
// backup-cell charger control, reached over avalon-mm with waitrequest
// assumes rst_n is the backup-domain power-on reset and pins are asynchronous
`include "btk_cfg.svh"

module btk_timekeeper (
  // clock and backup-domain reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  // avalon-mm slave
  input  wire logic [5:0]               avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic      [31:0]              avs_readdata,
  output logic                          avs_waitrequest,
  // asynchronous pins
  input  wire btk_pkg::btk_pins_t       pins,
  // outputs
  output logic                          slow_clock_out,
  output logic                          irq,
  output logic                          wake_req,
  output logic      [2:0]               charge_level,
  output btk_pkg::btk_power_t           power
);
  import btk_pkg::*;

  localparam int PIN_W = $bits(btk_pins_t);

  // byte-lane merge of a register with write data
  function automatic logic [31:0] lane_merge(input logic [31:0] old_val,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  be);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // address hit on a register word
  function automatic logic addr_hit(input logic [5:0] addr, input logic [5:0] reg_addr);
    return addr == reg_addr;
  endfunction

  // reset release through two flip-flops
  logic rst_ff1_reg;
  logic rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_ff1_reg <= 1'b0;
      rst_sync_n  <= 1'b0;
    end else begin
      rst_ff1_reg <= 1'b1;
      rst_sync_n  <= rst_ff1_reg;
    end
  end

  // pin synchronisers; first stage read only by the second
  logic [PIN_W-1:0] sync1_reg;
  logic [PIN_W-1:0] sync2_reg;
  btk_pins_t        pin_s;

  genvar g;
  generate
    for (g = 0; g < PIN_W; g++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g] <= pins[g];
          sync2_reg[g] <= sync1_reg[g];
        end
      end
    end
  endgenerate

  assign pin_s = btk_pins_t'(sync2_reg);

  // oscillator edge detect and untrimmed clock output
  logic osc_d_reg;
  logic osc_rise;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      osc_d_reg      <= 1'b0;
      slow_clock_out <= 1'b0;
    end else begin
      osc_d_reg      <= pin_s.osc_32k;
      slow_clock_out <= pin_s.osc_32k;
    end
  end

  assign osc_rise = pin_s.osc_32k && !osc_d_reg;

  // register state
  btk_ctrl_t                ctrl_reg;
  logic [`BTK_SEC_W-1:0]    seconds_of_date_counter_reg;
  logic [`BTK_DAY_W-1:0]    day_counter_reg;
  logic [`BTK_SEC_W-1:0]    alarm_seconds_reg;
  logic [`BTK_DAY_W-1:0]    alarm_date_reg;
  logic [`BTK_TRIM_W-1:0]   trim_word_reg;
  logic [`BTK_IRQ_W-1:0]    irq_flag_reg;
  logic [`BTK_IRQ_W-1:0]    irq_mask_reg;
  logic                     cell_connected_reg;
  logic                     on_backup_reg;

  // bus handshake: one wait state, then the access completes
  logic        bus_req;
  logic        bus_do_wr;
  logic [31:0] wmerge_ctrl;
  logic [31:0] wmerge_sec;
  logic [31:0] wmerge_day;
  logic [31:0] wmerge_asec;
  logic [31:0] wmerge_aday;
  logic [31:0] wmerge_trim;
  logic [31:0] wmerge_stat;
  logic [31:0] wmerge_mask;

  assign bus_req   = avs_read || avs_write;
  assign bus_do_wr = avs_write && !avs_waitrequest;

  assign wmerge_ctrl = lane_merge({{(32-`BTK_CTRL_W){1'b0}}, ctrl_reg},
                                  avs_writedata, avs_byteenable);
  assign wmerge_sec  = lane_merge({{(32-`BTK_SEC_W){1'b0}}, seconds_of_date_counter_reg},
                                  avs_writedata, avs_byteenable);
  assign wmerge_day  = lane_merge({{(32-`BTK_DAY_W){1'b0}}, day_counter_reg},
                                  avs_writedata, avs_byteenable);
  assign wmerge_asec = lane_merge({{(32-`BTK_SEC_W){1'b0}}, alarm_seconds_reg},
                                  avs_writedata, avs_byteenable);
  assign wmerge_aday = lane_merge({{(32-`BTK_DAY_W){1'b0}}, alarm_date_reg},
                                  avs_writedata, avs_byteenable);
  assign wmerge_trim = lane_merge({{(32-`BTK_TRIM_W){1'b0}}, trim_word_reg},
                                  avs_writedata, avs_byteenable);
  assign wmerge_mask = lane_merge({{(32-`BTK_IRQ_W){1'b0}}, irq_mask_reg},
                                  avs_writedata, avs_byteenable);
  // write-one-to-clear only through enabled lanes
  assign wmerge_stat = lane_merge(32'h00000000, avs_writedata, avs_byteenable);

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
    end
  end

  // trim enable by policy and supply path
  logic trim_en;
  logic tick;

  always_comb begin
    unique case (ctrl_reg.trim_policy)
      `BTK_POL_ALWAYS:    trim_en = 1'b1;
      `BTK_POL_MAIN_ONLY: trim_en = !on_backup_reg;
      default:            trim_en = 1'b0; // reserved code treated as off
    endcase
  end

  btk_divider u_divider (
    .sys_clk    (sys_clk),
    .rst_sync_n (rst_sync_n),
    .run        (!ctrl_reg.timekeeper_off),
    .trim_en    (trim_en),
    .trim_word  (trim_word_reg),
    .osc_rise   (osc_rise),
    .tick       (tick)
  );

  // control register; only backup reset clears the charger enable
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_reg <= `BTK_CTRL_RST;
    end else if (bus_do_wr && addr_hit(avs_address, `BTK_ADDR_CTRL)) begin
      ctrl_reg <= btk_ctrl_t'(wmerge_ctrl[`BTK_CTRL_W-1:0]);
    end
  end

  // time and day counters; a bus write wins over a same-cycle tick
  logic sec_wrap;

  assign sec_wrap = seconds_of_date_counter_reg == `BTK_SEC_LAST;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      seconds_of_date_counter_reg <= `BTK_SEC_RST;
    end else if (bus_do_wr && addr_hit(avs_address, `BTK_ADDR_SECONDS)) begin
      seconds_of_date_counter_reg <= wmerge_sec[`BTK_SEC_W-1:0];
    end else if (tick) begin
      if (sec_wrap) begin
        seconds_of_date_counter_reg <= `BTK_SEC_RST;
      end else begin
        seconds_of_date_counter_reg <= seconds_of_date_counter_reg + 17'h00001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      day_counter_reg <= `BTK_DAY_RST;
    end else if (bus_do_wr && addr_hit(avs_address, `BTK_ADDR_DAYS)) begin
      day_counter_reg <= wmerge_day[`BTK_DAY_W-1:0];
    end else if (tick && sec_wrap) begin
      day_counter_reg <= day_counter_reg + 15'h0001;
    end
  end

  // alarm, trim and mask registers
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      alarm_seconds_reg <= `BTK_SEC_RST;
      alarm_date_reg    <= `BTK_DAY_RST;
      trim_word_reg     <= `BTK_TRIM_RST;
      irq_mask_reg      <= `BTK_IRQ_MASK_RST;
    end else if (bus_do_wr) begin
      if (addr_hit(avs_address, `BTK_ADDR_ALARM_SEC)) begin
        alarm_seconds_reg <= wmerge_asec[`BTK_SEC_W-1:0];
      end
      if (addr_hit(avs_address, `BTK_ADDR_ALARM_DAY)) begin
        alarm_date_reg <= wmerge_aday[`BTK_DAY_W-1:0];
      end
      if (addr_hit(avs_address, `BTK_ADDR_TRIM)) begin
        trim_word_reg <= wmerge_trim[`BTK_TRIM_W-1:0];
      end
      if (addr_hit(avs_address, `BTK_ADDR_IRQ_MASK)) begin
        irq_mask_reg <= wmerge_mask[`BTK_IRQ_W-1:0];
      end
    end
  end

  // alarm compared the cycle after the tick, on the updated count
  logic tick_d_reg;
  logic alarm_hit;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tick_d_reg <= 1'b0;
    end else begin
      tick_d_reg <= tick;
    end
  end

  assign alarm_hit = tick_d_reg
                  && seconds_of_date_counter_reg == alarm_seconds_reg
                  && day_counter_reg == alarm_date_reg;

  // sticky flags: set wins over a same-cycle clear
  logic [`BTK_IRQ_W-1:0] flag_set;
  logic [`BTK_IRQ_W-1:0] flag_clr;

  always_comb begin
    flag_set                 = '0;
    flag_set[`BTK_IRQ_TICK]  = tick;
    flag_set[`BTK_IRQ_ALARM] = alarm_hit;
    if (bus_do_wr && addr_hit(avs_address, `BTK_ADDR_IRQ_STAT)) begin
      flag_clr = wmerge_stat[`BTK_IRQ_W-1:0];
    end else begin
      flag_clr = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_flag_reg <= `BTK_IRQ_STAT_RST;
    end else begin
      irq_flag_reg <= (irq_flag_reg & ~flag_clr) | flag_set;
    end
  end

  // pending unmasked flags drive the line, including after unmask
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_flag_reg & ~irq_mask_reg);
    end
  end

  // wake request only while the application is off
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wake_req <= 1'b0;
    end else if (pin_s.app_on) begin
      wake_req <= 1'b0;
    end else if (alarm_hit) begin
      wake_req <= 1'b1;
    end
  end

  // power path: backup cell takes over when main is low and cell is higher
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      on_backup_reg <= 1'b0;
    end else begin
      on_backup_reg <= pin_s.main_below_1v8 && pin_s.cell_above_main;
    end
  end

  // a fresh cell stays isolated until app_on, whatever the charger enable
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cell_connected_reg <= 1'b0;
    end else if (pin_s.app_on) begin
      cell_connected_reg <= 1'b1;
    end
  end

  // charger current selection and undervoltage stop
  logic charging;

  assign charging = ctrl_reg.charge_on && !pin_s.main_below_uv;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      power        <= '0;
      charge_level <= 3'h0;
    end else begin
      power.on_backup_power     <= on_backup_reg;
      power.cell_connected      <= cell_connected_reg;
      power.charge_current_high <= charging && pin_s.app_on;
      power.charge_current_low  <= charging && !pin_s.app_on;
      charge_level              <= ctrl_reg.charge_level;
    end
  end

  // read data captured at the wait-state edge; unmapped reads give zero
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h00000000;
    if (addr_hit(avs_address, `BTK_ADDR_CTRL)) begin
      rd_mux[`BTK_CTRL_W-1:0] = ctrl_reg;
    end
    if (addr_hit(avs_address, `BTK_ADDR_SECONDS)) begin
      rd_mux[`BTK_SEC_W-1:0] = seconds_of_date_counter_reg;
    end
    if (addr_hit(avs_address, `BTK_ADDR_DAYS)) begin
      rd_mux[`BTK_DAY_W-1:0] = day_counter_reg;
    end
    if (addr_hit(avs_address, `BTK_ADDR_ALARM_SEC)) begin
      rd_mux[`BTK_SEC_W-1:0] = alarm_seconds_reg;
    end
    if (addr_hit(avs_address, `BTK_ADDR_ALARM_DAY)) begin
      rd_mux[`BTK_DAY_W-1:0] = alarm_date_reg;
    end
    if (addr_hit(avs_address, `BTK_ADDR_TRIM)) begin
      rd_mux[`BTK_TRIM_W-1:0] = trim_word_reg;
    end
    if (addr_hit(avs_address, `BTK_ADDR_IRQ_STAT)) begin
      rd_mux[`BTK_IRQ_W-1:0] = irq_flag_reg;
    end
    if (addr_hit(avs_address, `BTK_ADDR_IRQ_MASK)) begin
      rd_mux[`BTK_IRQ_W-1:0] = irq_mask_reg;
    end
    if (addr_hit(avs_address, `BTK_ADDR_STATUS)) begin
      rd_mux[`BTK_STATUS_W-1:0] = {wake_req, charging, cell_connected_reg, on_backup_reg};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_mux;
    end
  end

endmodule

// [test/btk_timekeeper_props.sv]
// checker of the timekeeper ports: bus handshake, charger and power outputs
// assumes one sys_clk domain and binding onto btk_timekeeper
module btk_timekeeper_props import btk_pkg::*; (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // avalon-mm
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // pins and outputs
  input wire btk_pins_t   pins,
  input wire logic        slow_clock_out,
  input wire logic        irq,
  input wire logic        wake_req,
  input wire logic [2:0]  charge_level,
  input wire btk_power_t  power
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // cycles since reset release, saturating; hides flops still in internal reset
  logic [3:0] up_cnt_reg;
  logic       ctrl_wr;
  assign ctrl_wr = avs_write && !avs_waitrequest && (avs_address == 6'h00);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) up_cnt_reg <= 4'h0;
    else if (up_cnt_reg != 4'hf) up_cnt_reg <= up_cnt_reg + 4'h1;
  end

  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    && up_cnt_reg > 4'h3 |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_rdata_cause: assert property ($changed(avs_readdata)
    |-> $past(avs_read && avs_waitrequest))
    else $error("readdata changed without a read");
  a_irq_quiet: assert property (up_cnt_reg != 4'hf |-> !irq)
    else $error("irq raised while all masks set after reset");
  a_wake_clear: assert property (pins.app_on [*5] |-> !wake_req)
    else $error("wake request while application on");
  a_level_write: assert property ($changed(charge_level)
    |-> $past(ctrl_wr, 1) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3))
    else $error("charge level changed without control write");
  a_current_excl: assert property (!(power.charge_current_high
    && power.charge_current_low))
    else $error("both charge currents selected");
  a_uv_stop: assert property (pins.main_below_uv [*6]
    |-> !power.charge_current_high && !power.charge_current_low)
    else $error("charging under undervoltage");
  a_mains_ok: assert property ((!pins.main_below_1v8) [*6] ##0 (up_cnt_reg == 4'hf)
    |-> !power.on_backup_power)
    else $error("backup power while main supply valid");
  a_cell_hold: assert property (power.cell_connected |=> power.cell_connected)
    else $error("cell disconnected without reset");
  a_slow_clk: assert property (up_cnt_reg == 4'hf
    |-> slow_clock_out == $past(pins.osc_32k, 3))
    else $error("slow clock output not the untrimmed oscillator");

  c_read: cover property (avs_read && !avs_waitrequest);
  c_irq: cover property ($rose(irq));
  c_wake: cover property ($rose(wake_req));
endmodule

bind btk_timekeeper btk_timekeeper_props btk_timekeeper_props_inst (.sys_clk, .rst_n,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .pins, .slow_clock_out, .irq, .wake_req, .charge_level, .power);

// [test/btk_host_model.sv]
// host processor model: avalon-mm master, one transfer at a time
// assumes the bench watchdog ends a wait that never completes
module btk_host_model (
  // clock and answer
  input  wire logic        sys_clk,
  input  wire logic        avs_waitrequest,
  // request
  output logic [5:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable,
  // slow slave seen
  output logic             stall_seen
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    avs_address = 6'h3f;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    stall_seen = 1'b0;
  end

  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] be);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    // slow answer only flagged; the wait itself is ended by the watchdog
    if (n > 2) stall_seen <= 1'b1;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // released lines do not keep the last value
    avs_address <= ~a;
    avs_writedata <= ~d;
    avs_byteenable <= ~be;
  endtask

  // correction word found by measuring against a better clock
  task automatic set_trim(input logic [4:0] code);
    xfer(1'b1, 6'h14, {27'h0, code}, 4'hf);
  endtask
endmodule

// [test/btk_timekeeper_test.sv]
// self-checking bench of the timekeeper: host model, pin stimulus, read scoreboard
// assumes the oscillator pin may toggle every bus clock cycle
`include "btk_cfg.svh"
module btk_timekeeper_test import btk_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic        sys_clk, rst_n, avs_read, avs_write, avs_waitrequest, stall_seen;
  logic        slow_clock_out, irq, wake_req;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, v, day;
  logic [3:0]  avs_byteenable;
  logic [2:0]  charge_level;
  btk_pins_t   pins;
  btk_power_t  power;
  int          mismatches, samples_checked, seed;
  logic [31:0] exp_q[$];
  logic [31:0] msk [5] = '{32'h1ffff, 32'h7fff, 32'h1ffff, 32'h7fff, 32'h1f};
  logic [1:0]  pol [3] = '{2'h0, 2'h1, 2'h3};

  btk_timekeeper btk_timekeeper_inst (.sys_clk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .pins, .slow_clock_out, .irq, .wake_req, .charge_level, .power);
  btk_host_model btk_host_model_inst (.sys_clk, .avs_waitrequest, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .stall_seen);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    btk_host_model_inst.xfer(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    btk_host_model_inst.xfer(1'b0, a, 32'h0, 4'hf);
  endtask
  task automatic osc(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      pins.osc_32k <= 1'b1;
      @(posedge sys_clk);
      pins.osc_32k <= 1'b0;
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // read data is judged at the edge that ends the access
  always @(posedge sys_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) chk("spare read", 32'h1, 32'h0);
      else chk("readdata", avs_readdata, exp_q.pop_front());
    end
  end

  initial begin
    #2500000;
    mismatches++;
    test_done();
  end

  initial begin
    seed = 38;
    rst_n = 1'b0;
    pins = '0;
    mismatches = 0;
    samples_checked = 0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(`BTK_ADDR_CTRL, 32'h0);
    rd(`BTK_ADDR_IRQ_STAT, 32'h4);
    rd(`BTK_ADDR_IRQ_MASK, 32'h7);
    rd(`BTK_ADDR_SECONDS, 32'h0);
    for (int i = 0; i < 5; i++) begin
      v = $random(seed) & msk[i];
      if (msk[i] == 32'h1ffff) v = v % 86400;
      wr(6'(4 + 4 * i), v);
      rd(6'(4 + 4 * i), v);
    end
    for (int lv = 0; lv < 8; lv++) begin
      v = {25'h0, pol[lv % 3], 3'(lv), 2'b00};
      wr(`BTK_ADDR_CTRL, v);
      rd(`BTK_ADDR_CTRL, v);
      chk("charge_level", 32'(charge_level), 32'(lv));
    end
    wr(6'h24, $random(seed));
    rd(6'h24, 32'h0);
    // one tick: seconds at the last value of the day, trim -16, policy always
    day = $random(seed) & 32'h7ffe;
    wr(`BTK_ADDR_SECONDS, 32'h1517f);
    wr(`BTK_ADDR_DAYS, day);
    wr(`BTK_ADDR_ALARM_SEC, 32'h0);
    wr(`BTK_ADDR_ALARM_DAY, day + 1);
    btk_host_model_inst.set_trim(5'h10);
    wr(`BTK_ADDR_CTRL, 32'h76);
    wr(`BTK_ADDR_IRQ_MASK, 32'h4);
    repeat (8) @(posedge sys_clk);
    chk("low current", 32'(power.charge_current_low), 32'h1);
    chk("cell", 32'(power.cell_connected), 32'h0);
    osc(32000);
    // stopped divider must hold its phase, so these edges must not tick
    wr(`BTK_ADDR_CTRL, 32'h77);
    osc(800);
    wr(`BTK_ADDR_CTRL, 32'h76);
    rd(`BTK_ADDR_SECONDS, 32'h1517f);
    osc(751);
    repeat (20) @(posedge sys_clk);
    chk("irq early", 32'(irq), 32'h0);
    osc(1);
    repeat (20) @(posedge sys_clk);
    chk("irq tick", 32'(irq), 32'h1);
    chk("wake", 32'(wake_req), 32'h1);
    rd(`BTK_ADDR_IRQ_STAT, 32'h7);
    rd(`BTK_ADDR_SECONDS, 32'h0);
    rd(`BTK_ADDR_DAYS, (day + 1) & 32'h7fff);
    wr(`BTK_ADDR_IRQ_STAT, 32'h3);
    repeat (3) @(posedge sys_clk);
    chk("irq cleared", 32'(irq), 32'h0);
    rd(`BTK_ADDR_IRQ_STAT, 32'h4);
    wr(`BTK_ADDR_IRQ_MASK, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk("irq unmask", 32'(irq), 32'h1);
    wr(`BTK_ADDR_IRQ_STAT, 32'h4);
    repeat (3) @(posedge sys_clk);
    chk("irq lost", 32'(irq), 32'h0);
    pins.app_on <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk("wake off", 32'(wake_req), 32'h0);
    chk("cell on", 32'(power.cell_connected), 32'h1);
    chk("high current", 32'({power.charge_current_high, power.charge_current_low}),
      32'h2);
    pins.main_below_uv <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk("uv stop", 32'(power.charge_current_high), 32'h0);
    pins.main_below_1v8 <= 1'b1;
    pins.cell_above_main <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk("backup", 32'(power.on_backup_power), 32'h1);
    // only the low byte lane of the write may land
    btk_host_model_inst.xfer(1'b1, `BTK_ADDR_SECONDS, 32'h0001ff33, 4'h1);
    rd(`BTK_ADDR_SECONDS, 32'h33);
    rst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(`BTK_ADDR_CTRL, 32'h0);
    rd(`BTK_ADDR_IRQ_STAT, 32'h4);
    rd(`BTK_ADDR_DAYS, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk("stall", 32'(stall_seen), 32'h0);
    test_done();
  end
endmodule
